// >>> logic/hpp_pkg.sv
// constants and types for the host parallel register port
// assumes one 50 MHz clock, asynchronous active-low reset
// Operation
// R1 - timing select high: accesses timed by the host-supplied sync clock
// R2 - timing select low: accesses timed by the internal clock
// R3 - host supplies free-running square-wave sync clock in synchronous mode
// R4 - no access starts unless select is low; high select means idle
// R5 - selected with store strobe low: data written to addressed register
// R6 - selected with read strobe low: addressed register driven to host
// R7 - device asserts completion low when done; host waits for it
// R8 - board routes rate C reference to rate B input for access clock
// R9 - factory mode input held at ground for normal operation
// R10 - eight-bit direct address selects the register of each access
// R11 - eight-bit two-way data bus: host drives writes, device reads
// R12 - data driven only while selected and reading, released otherwise
// R13 - completion released high once the host deasserts select
package hpp_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int REG_N  = 256;
    localparam logic [7:0] REG_RESET = 8'h00;
    // internal clock cycles an access takes in asynchronous mode
    localparam int ACC_NS   = 60;
    localparam int CLK_NS   = 20;
    localparam int ACC_CYC  = (ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [2:0] ACC_CYC3 = 3'(ACC_CYC);
    // two-bit access states; HPP_DONE to HPP_IDLE flips both bits
    typedef enum logic [1:0] {
        HPP_IDLE = 2'b00,
        HPP_WAIT = 2'b01,
        HPP_DONE = 2'b11
    } hpp_state_t;
endpackage

// >>> logic/hpp_port.sv
// host parallel register port with an 8-bit register file
// assumes host pins are asynchronous to ref_clk; synced here
module hpp_port (
    input  wire logic                      ref_clk,
    input  wire logic                      rst_n,
    input  wire logic                      timingSel,
    input  wire logic                      hostSyncClk,
    input  wire logic                      selN,
    input  wire logic                      storeN,
    input  wire logic                      readN,
    input  wire logic [hpp_pkg::ADDR_W-1:0] addr,
    input  wire logic [hpp_pkg::DATA_W-1:0] dataIn,
    output logic      [hpp_pkg::DATA_W-1:0] dataOut,
    output logic                           dataOeN,
    output logic                           doneN
);
    import hpp_pkg::*;

    // two-flop synchronisers for all host pins
    logic [4:0] syncA_q, syncB_q;
    logic [ADDR_W-1:0] addrA_q, addrB_q;
    logic [DATA_W-1:0] dinA_q, dinB_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            syncA_q <= 5'h1F;
            syncB_q <= 5'h1F;
            addrA_q <= 8'h00;
            addrB_q <= 8'h00;
            dinA_q  <= 8'h00;
            dinB_q  <= 8'h00;
        end else begin
            syncA_q <= {timingSel, hostSyncClk, selN, storeN, readN};
            syncB_q <= syncA_q;
            addrA_q <= addr;
            addrB_q <= addrA_q;
            dinA_q  <= dataIn;
            dinB_q  <= dinA_q;
        end
    end
    logic modeSync, pclk, sel, store, rd;
    assign modeSync = syncB_q[4];
    assign pclk     = syncB_q[3];
    assign sel      = ~syncB_q[2];
    assign store    = ~syncB_q[1];
    assign rd       = ~syncB_q[0];

    // host clock rising-edge detect, read from the second flop only
    logic pclkOld_q, pclkRise;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pclkOld_q <= 1'b1;
        end else begin
            pclkOld_q <= pclk;
        end
    end
    assign pclkRise = pclk & ~pclkOld_q;

    // R1 host clock tick
    // R2 internal tick
    logic tick;
    assign tick = modeSync ? pclkRise : 1'b1;

    hpp_state_t state_q, state_d;
    logic [2:0] cnt_q, cnt_d;
    logic [DATA_W-1:0] regs_q [REG_N];
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic doneN_q, doneN_d, oeN_q, oeN_d, wrEn;

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        rdata_d = rdata_q;
        doneN_d = doneN_q;
        oeN_d   = oeN_q;
        wrEn    = 1'b0;
        case (state_q)
            HPP_IDLE: begin
                // R4 start only selected
                if (sel && (store || rd)) begin
                    state_d = HPP_WAIT;
                    cnt_d   = 3'd0;
                end
            end
            HPP_WAIT: begin
                if (!sel) begin
                    state_d = HPP_IDLE;
                end else if (tick) begin
                    cnt_d = cnt_q + 3'd1;
                    if (cnt_q + 3'd1 >= ACC_CYC3) begin
                        state_d = HPP_DONE;
                        // R10 direct address
                        // R5 store to register
                        wrEn    = store;
                        // R6 read register
                        rdata_d = regs_q[addrB_q];
                        // R7 completion asserted
                        doneN_d = 1'b0;
                    end
                end
            end
            HPP_DONE: begin
                // R13 release on deselect
                if (!sel) begin
                    state_d = HPP_IDLE;
                    doneN_d = 1'b1;
                end
            end
            default: begin
                state_d = HPP_IDLE;
                doneN_d = 1'b1;
            end
        endcase
        // R12 drive only when reading
        // R11 device drives reads
        oeN_d = ~(sel && rd && state_d == HPP_DONE);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= HPP_IDLE;
            cnt_q   <= 3'd0;
            rdata_q <= 8'h00;
            doneN_q <= 1'b1;
            oeN_q   <= 1'b1;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            rdata_q <= rdata_d;
            doneN_q <= doneN_d;
            oeN_q   <= oeN_d;
        end
    end

    // register file, one generate entry per address
    for (genvar i = 0; i < REG_N; i++) begin : gReg
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                regs_q[i] <= REG_RESET;
            end else if (wrEn && addrB_q == 8'(i)) begin
                regs_q[i] <= dinB_q;
            end
        end
    end

    assign dataOut = rdata_q;
    assign dataOeN = oeN_q;
    assign doneN   = doneN_q;

    // host-edge count for the sync timing check
    logic [2:0] hostTicks_q, hostTicks_d;
    always_comb begin
        hostTicks_d = hostTicks_q;
        if (!sel) begin
            hostTicks_d = 3'h0;
        end else if (pclkRise && hostTicks_q != 3'h7) begin
            hostTicks_d = hostTicks_q + 3'h1;
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hostTicks_q <= 3'h0;
        end else begin
            hostTicks_q <= hostTicks_d;
        end
    end

    // access shapes
    sequence seqAsyncReadStart;
        !modeSync && state_q == HPP_IDLE && sel && rd;
    endsequence
    sequence seqSelHeld3;
        sel[*3];
    endsequence
    sequence seqDoneHeld;
        state_q == HPP_DONE && sel;
    endsequence

    // R4 idle when deselected
    AST_IDLE_NO_DONE: assert property ( // R4
        @(posedge ref_clk) disable iff (!rst_n)
        !sel |=> (doneN && dataOeN))
        else $error("port active while deselected");

    // R13 release after deselect
    AST_DONE_RELEASE: assert property ( // R13
        @(posedge ref_clk) disable iff (!rst_n)
        (state_q == HPP_DONE && !sel) |=> doneN)
        else $error("completion not released");

    // R12 drive only reading
    AST_OE_READ: assert property ( // R12
        @(posedge ref_clk) disable iff (!rst_n)
        !dataOeN |-> $past(sel && rd))
        else $error("data driven outside read");

    // R2 internal clock timing
    AST_ASYNC_TIME: assert property ( // R2
        @(posedge ref_clk) disable iff (!rst_n)
        (seqAsyncReadStart ##1 seqSelHeld3) |=> !doneN)
        else $error("async access not completed in time");

    // R7 completion needs tick
    AST_DONE_CAUSE: assert property ( // R7
        @(posedge ref_clk) disable iff (!rst_n)
        $fell(doneN) |-> $past(tick && state_q == HPP_WAIT))
        else $error("completion without tick");

    // R1 host clock paces
    AST_SYNC_TICK: assert property ( // R1
        @(posedge ref_clk) disable iff (!rst_n)
        (modeSync && state_q == HPP_WAIT && !pclkRise) |=> $stable(cnt_q))
        else $error("sync access advanced without host clock");

    // R1 three host edges
    AST_SYNC_TIME: assert property ( // R1
        @(posedge ref_clk) disable iff (!rst_n)
        (modeSync && $fell(doneN)) |-> hostTicks_q >= ACC_CYC3)
        else $error("sync access completed too early");

    // R5 write stored
    AST_WRITE: assert property ( // R5
        @(posedge ref_clk) disable iff (!rst_n)
        wrEn |=> regs_q[$past(addrB_q)] == $past(dinB_q))
        else $error("write not stored");

    // R5 write only selected
    AST_WRITE_GATED: assert property ( // R5
        @(posedge ref_clk) disable iff (!rst_n)
        wrEn |-> (sel && store && state_q == HPP_WAIT))
        else $error("write outside a selected store");

    // R6 read data
    AST_READ: assert property ( // R6
        @(posedge ref_clk) disable iff (!rst_n)
        (state_q == HPP_WAIT && state_d == HPP_DONE && rd)
        |=> dataOut == $past(regs_q[addrB_q]))
        else $error("read data wrong");

    // R7 completion stands
    AST_DONE_HOLD: assert property ( // R7
        @(posedge ref_clk) disable iff (!rst_n)
        seqDoneHeld |=> !doneN)
        else $error("completion dropped while selected");

    // R12 drive with completion
    AST_OE_WITH_DONE: assert property ( // R12
        @(posedge ref_clk) disable iff (!rst_n)
        !dataOeN |-> !doneN)
        else $error("data driven before completion");

    // R4 abort on deselect
    AST_ABORT_IDLE: assert property ( // R4
        @(posedge ref_clk) disable iff (!rst_n)
        (state_q == HPP_WAIT && !sel) |=> (state_q == HPP_IDLE && doneN))
        else $error("aborted access not idle");
endmodule

// >>> tb/hpp_host_model.sv
// host model: strobes, address, data wire, sync clock
// assumes ref_clk shared with the port under test
module hpp_host_model (
    input  wire logic       ref_clk,
    input  wire logic [7:0] dataOut,
    input  wire logic       dataOeN,
    input  wire logic       doneN,
    output logic            hostSyncClk,
    output logic            selN,
    output logic            storeN,
    output logic            readN,
    output logic [7:0]      addr,
    output logic [7:0]      dataIn
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] wrData = 8'h00;
    logic       drv = 1'b0;
    assign dataIn = !dataOeN ? dataOut : (drv ? wrData : ~wrData);
    initial hostSyncClk = 1'b0;
    always #50 hostSyncClk = ~hostSyncClk;
    initial {selN, storeN, readN, addr} = 11'h700;
    task automatic hold(input logic s, w, r, input logic [7:0] a, d,
                        input int n);
        @(posedge ref_clk);
        {selN, storeN, readN, addr, wrData, drv} <= {s, w, r, a, d, !w};
        repeat (n - 1) @(posedge ref_clk);
    endtask
    task automatic access(input logic w, input logic [7:0] a, d,
                          output logic [7:0] rd, output logic oe, ok);
        int k;
        hold(1'b0, !w, w, a, d, 1);
        for (k = 0; doneN !== 1'b0 && k < 40; k++) @(negedge ref_clk);
        oe = dataOeN;
        ok = (k < 40);
        rd = dataOut;
        @(posedge ref_clk);
        {selN, storeN, readN, drv} <= 4'hE;
        for (k = 0; doneN !== 1'b1 && k < 10; k++) @(negedge ref_clk);
    endtask
endmodule

// >>> tb/hpp_port_tb.sv
// bench for the host parallel register port
// assumes a 50 MHz ref_clk and the host model beside it
module hpp_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic       ref_clk = 0, rst_n = 0, timingSel = 0;
    logic       hostSyncClk, selN, storeN, readN, doneN, dataOeN, oe, ok;
    logic [7:0] addr, dataIn, dataOut, rd;
    int         mismatches = 0, cmp_count = 0, cycles = 0;
    always #10 ref_clk = ~ref_clk;
    hpp_host_model host (.ref_clk(ref_clk), .dataOut(dataOut),
        .dataOeN(dataOeN), .doneN(doneN), .hostSyncClk(hostSyncClk),
        .selN(selN), .storeN(storeN), .readN(readN), .addr(addr),
        .dataIn(dataIn));
    hpp_port uut (.ref_clk(ref_clk), .rst_n(rst_n), .timingSel(timingSel),
        .hostSyncClk(hostSyncClk), .selN(selN), .storeN(storeN),
        .readN(readN), .addr(addr), .dataIn(dataIn), .dataOut(dataOut),
        .dataOeN(dataOeN), .doneN(doneN));
    task automatic check(input logic [7:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            report_and_stop();
        end
    end
    task automatic t_rw(input logic mode);
        logic [7:0] a;
        logic [7:0] key;
        key = mode ? 8'hC3 : 8'h3C;
        @(posedge ref_clk);
        timingSel <= mode;
        repeat (4) @(posedge ref_clk);
        for (int i = 0; i < 4; i++) begin
            a = 8'h55 * i[7:0];
            host.access(1'b1, a, a ^ key, rd, oe, ok);
            check(ok, 1'b1);
            check(oe, 1'b1);
        end
        for (int i = 0; i < 4; i++) begin
            a = 8'h55 * i[7:0];
            host.access(1'b0, a, 8'h00, rd, oe, ok);
            check(rd, a ^ key);
            check(oe, 1'b0);
            check(dataOeN, 1'b1);
        end
        $display("read-write test done, mode %0d", mode);
    endtask
    task automatic t_idle_abort();
        host.hold(1'b1, 1'b0, 1'b0, 8'h11, 8'hEE, 20);
        check(doneN, 1'b1);
        check(dataOeN, 1'b1);
        host.hold(1'b0, 1'b0, 1'b1, 8'h22, 8'h77, 2);
        host.hold(1'b1, 1'b1, 1'b1, 8'h22, 8'h77, 12);
        check(doneN, 1'b1);
        host.access(1'b0, 8'h11, 8'h00, rd, oe, ok);
        check(rd, hpp_pkg::REG_RESET);
        host.access(1'b0, 8'h22, 8'h00, rd, oe, ok);
        check(rd, hpp_pkg::REG_RESET);
        $display("idle and abort test done");
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        check(doneN, 1'b1);
        check(dataOeN, 1'b1);
        rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        t_idle_abort();
        t_rw(1'b0);
        t_rw(1'b1);
        report_and_stop();
    end
endmodule
